// [hw/isp_slave.sv]
// Behaviour
// - Serial port runs two-wire when select low
// - SDA changes only while SCL low
// - Detect START and STOP while SCL high
// - Only master creates START, STOP, restarts
// - Bus busy from START until STOP
// - Repeated START restarts address reception
// - Bytes are eight bits, MSB first
// - Master clocks the acknowledge pulse
// - Transmitter releases, receiver pulls low on ninth
// - Addressed device acknowledges every received byte
// - First byte: seven-bit address plus direction
// - Address 20h, or 21h when select high
// - Write: second byte register, third data
// - Master writes register address before reading
// - Register address increments after each data byte
`timescale 1ns/1ps
module isp_slave
    import isp_pkg::*;
(
    input wire logic CORE_CLK_I,
    input wire logic RST_B_I,
    input wire logic IF_SEL_I,
    input wire logic ADDR_SEL_I,
    isp_bus_if.dev BUS,
    output logic [7:0] REG_ADDR_O,
    output logic [7:0] WR_DATA_O,
    output logic WR_STB_O,
    input wire logic [7:0] RD_DATA_I,
    output logic BUSY_O
);
    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_ADDR = 3'b001,
        ST_REG = 3'b010,
        ST_WDATA = 3'b011,
        ST_RDATA = 3'b100
    } isp_state_e;

    logic [2:0] scl_sync_ff;
    logic [2:0] sda_sync_ff;
    logic [2:0] sel_sync_ff;
    logic [1:0] ifs_sync_ff;
    isp_state_e state_ff;
    logic [3:0] bit_cnt_ff;
    logic [7:0] shift_ff;
    logic [7:0] reg_addr_ff;
    logic [7:0] wr_data_ff;
    logic wr_stb_ff;
    logic busy_ff;
    logic sda_low_ff;
    logic ack_phase_ff;
    logic scl_rise, scl_fall, start_det, stop_det, active;
    logic [6:0] my_addr;
    logic [7:0] rx_byte;
    logic byte_end;

    always_ff @(posedge CORE_CLK_I or negedge RST_B_I) begin
        if (!RST_B_I) begin
            scl_sync_ff <= 3'h7;
            sda_sync_ff <= 3'h7;
            sel_sync_ff <= 3'h0;
            ifs_sync_ff <= 2'h3;
        end else begin
            scl_sync_ff <= {scl_sync_ff[1:0], BUS.scl};
            sda_sync_ff <= {sda_sync_ff[1:0], BUS.sda};
            sel_sync_ff <= {sel_sync_ff[1:0], ADDR_SEL_I};
            ifs_sync_ff <= {ifs_sync_ff[0], IF_SEL_I};
        end
    end

    // Interface select is a static strap; a change mid-frame simply drops the frame
    assign active = ~ifs_sync_ff[1];
    assign scl_rise = scl_sync_ff[1] & ~scl_sync_ff[2];
    assign scl_fall = ~scl_sync_ff[1] & scl_sync_ff[2];
    assign start_det = active & scl_sync_ff[2] & scl_sync_ff[1]
        & sda_sync_ff[2] & ~sda_sync_ff[1];
    assign stop_det = active & scl_sync_ff[2] & scl_sync_ff[1]
        & ~sda_sync_ff[2] & sda_sync_ff[1];
    assign my_addr = sel_sync_ff[2] ? ADDR_ALT : ADDR_BASE;
    assign rx_byte = {shift_ff[6:0], sda_sync_ff[2]};
    // Falling SCL edge that ends the eighth bit, outside START and STOP handling
    assign byte_end = active && !start_det && !stop_det && state_ff != ST_IDLE
        && scl_fall && !ack_phase_ff && bit_cnt_ff == ACK_SLOT;

    always_ff @(posedge CORE_CLK_I or negedge RST_B_I) begin
        if (!RST_B_I) begin
            busy_ff <= 1'b0;
        end else if (start_det) begin
            busy_ff <= 1'b1;
        end else if (stop_det || !active) begin
            busy_ff <= 1'b0;
        end
    end

    always_ff @(posedge CORE_CLK_I or negedge RST_B_I) begin
        if (!RST_B_I) begin
            state_ff <= ST_IDLE;
            bit_cnt_ff <= 4'h0;
            shift_ff <= REG_RESET;
            sda_low_ff <= 1'b0;
            ack_phase_ff <= 1'b0;
        end else begin
            if (start_det) begin
                // Repeated START behaves like the first one
                state_ff <= ST_ADDR;
                bit_cnt_ff <= 4'h0;
                sda_low_ff <= 1'b0;
                ack_phase_ff <= 1'b0;
            end else if (stop_det || !active) begin
                state_ff <= ST_IDLE;
                sda_low_ff <= 1'b0;
                ack_phase_ff <= 1'b0;
            end else if (state_ff != ST_IDLE) begin
                if (scl_rise && !ack_phase_ff) begin
                    shift_ff <= rx_byte;
                    bit_cnt_ff <= bit_cnt_ff + 4'h1;
                end
                if (scl_rise && ack_phase_ff && state_ff == ST_RDATA) begin
                    if (sda_sync_ff[2]) begin
                        state_ff <= ST_IDLE;
                    end
                end
                // SDA only moves after a falling SCL edge, keeping it stable while high
                if (scl_fall) begin
                    if (ack_phase_ff) begin
                        ack_phase_ff <= 1'b0;
                        bit_cnt_ff <= 4'h0;
                        if (state_ff == ST_RDATA) begin
                            shift_ff <= RD_DATA_I;
                            sda_low_ff <= ~RD_DATA_I[BYTE_BITS-1];
                        end else begin
                            sda_low_ff <= 1'b0;
                        end
                    end else if (bit_cnt_ff == ACK_SLOT) begin
                        ack_phase_ff <= 1'b1;
                        sda_low_ff <= 1'b0;
                        unique case (state_ff)
                            ST_ADDR: begin
                                if (shift_ff[7:1] == my_addr) begin
                                    sda_low_ff <= 1'b1;
                                    state_ff <= shift_ff[0] ? ST_RDATA : ST_REG;
                                end else begin
                                    state_ff <= ST_IDLE;
                                    ack_phase_ff <= 1'b0;
                                end
                            end
                            ST_REG: begin
                                sda_low_ff <= 1'b1;
                                state_ff <= ST_WDATA;
                            end
                            ST_WDATA: begin
                                sda_low_ff <= 1'b1;
                            end
                            ST_RDATA: begin
                                // Master acks here; device has released SDA
                            end
                            default: begin
                                state_ff <= ST_IDLE;
                            end
                        endcase
                    end else if (state_ff == ST_RDATA) begin
                        if (bit_cnt_ff < BIT_LAST + 4'h1 && bit_cnt_ff != 4'h0) begin
                            sda_low_ff <= ~shift_ff[BYTE_BITS-1];
                        end
                    end
                end
            end
        end
    end

    // Write port: one strobe for every stored data byte
    // The strobe lands a cycle after the byte ends; the pointer steps a cycle later
    always_ff @(posedge CORE_CLK_I or negedge RST_B_I) begin
        if (!RST_B_I) begin
            wr_stb_ff <= 1'b0;
            wr_data_ff <= REG_RESET;
        end else begin
            wr_stb_ff <= byte_end && state_ff == ST_WDATA;
            if (byte_end && state_ff == ST_WDATA) begin
                wr_data_ff <= shift_ff;
            end
        end
    end

    // Advance after each data byte so bursts reach successive registers
    // Reads step at their own byte end, writes once the strobe has fired
    always_ff @(posedge CORE_CLK_I or negedge RST_B_I) begin
        if (!RST_B_I) begin
            reg_addr_ff <= REG_RESET;
        end else if (byte_end && state_ff == ST_REG) begin
            reg_addr_ff <= shift_ff;
        end else if (wr_stb_ff || (byte_end && state_ff == ST_RDATA)) begin
            reg_addr_ff <= reg_addr_ff + 8'h01;
        end
    end

    // Read shifts left on each rise so bit 7 of shift_ff is next to send
    assign BUS.sda_dev_o = 1'b0;
    assign BUS.sda_dev_oe = sda_low_ff;
    assign REG_ADDR_O = reg_addr_ff;
    assign WR_DATA_O = wr_data_ff;
    assign WR_STB_O = wr_stb_ff;
    assign BUSY_O = busy_ff;
endmodule : isp_slave

// [hw/isp_pkg.sv]
package isp_pkg;
    localparam logic [6:0] ADDR_BASE = 7'h20;
    localparam logic [6:0] ADDR_ALT = 7'h21;
    localparam int BYTE_BITS = 8;
    localparam logic [3:0] ACK_SLOT = 4'h8;
    localparam logic [3:0] BIT_LAST = 4'h7;
    localparam logic [7:0] REG_RESET = 8'h00;
    localparam int CORE_CLK_HZ = 20000000;
    localparam int SCL_HZ = 100000;
    localparam int SCL_HALF_CYC = CORE_CLK_HZ / (2 * SCL_HZ);
    localparam logic [7:0] SCL_HALF = 8'(SCL_HALF_CYC);
endpackage : isp_pkg

// [hw/isp_bus_if.sv]
`timescale 1ns/1ps
interface isp_bus_if;
    logic scl_o;
    logic scl_oe;
    logic sda_dev_o;
    logic sda_dev_oe;
    logic sda_mst_o;
    logic sda_mst_oe;
    logic scl;
    logic sda;
    assign scl = scl_oe ? scl_o : 1'b1;
    assign sda = ~((sda_dev_oe & ~sda_dev_o) | (sda_mst_oe & ~sda_mst_o));
    modport dev (input scl, input sda, output sda_dev_o, output sda_dev_oe);
    modport mst (input scl, input sda, output scl_o, output scl_oe,
                 output sda_mst_o, output sda_mst_oe);
endinterface : isp_bus_if

// [hw/isp_master.sv]
`timescale 1ns/1ps
module isp_master
    import isp_pkg::*;
(
    input wire logic CORE_CLK_I,
    input wire logic RST_B_I,
    isp_bus_if.mst BUS,
    input wire logic REQ_I,
    input wire logic RD_I,
    input wire logic [6:0] DEV_ADDR_I,
    input wire logic [7:0] REG_I,
    input wire logic [7:0] DATA_I,
    output logic READY_O,
    output logic DONE_O,
    output logic ACK_ERR_O,
    output logic [7:0] RDATA_O
);
    typedef enum logic [2:0] {
        M_IDLE = 3'b000,
        M_START = 3'b001,
        M_BYTE = 3'b010,
        M_RSTART = 3'b011,
        M_STOP = 3'b100
    } isp_mstate_e;

    isp_mstate_e st_ff;
    logic [7:0] div_ff;
    logic [1:0] ph_ff;
    logic [3:0] bit_ff;
    logic [1:0] idx_ff;
    logic [7:0] tx_ff;
    logic [7:0] rx_ff;
    logic scl_ff, sda_ff, rd_ff, err_ff, done_ff;
    logic [7:0] reg_ff, dat_ff;
    logic [6:0] dev_ff;
    logic [1:0] sda_sync_ff;
    logic tick, rx_byte, last;

    assign tick = (div_ff == SCL_HALF - 8'h01);
    // Read frame: addr(w), reg, restart, addr(r), data
    assign rx_byte = rd_ff && idx_ff == 2'h3;
    assign last = idx_ff == 2'h2 && !rd_ff || idx_ff == 2'h3;

    always_ff @(posedge CORE_CLK_I or negedge RST_B_I) begin
        if (!RST_B_I) begin
            div_ff <= 8'h00;
            sda_sync_ff <= 2'h3;
        end else begin
            div_ff <= tick ? 8'h00 : div_ff + 8'h01;
            sda_sync_ff <= {sda_sync_ff[0], BUS.sda};
        end
    end

    always_ff @(posedge CORE_CLK_I or negedge RST_B_I) begin
        if (!RST_B_I) begin
            st_ff <= M_IDLE;
            ph_ff <= 2'h0;
            bit_ff <= 4'h0;
            idx_ff <= 2'h0;
            tx_ff <= 8'h00;
            rx_ff <= 8'h00;
            scl_ff <= 1'b1;
            sda_ff <= 1'b1;
            rd_ff <= 1'b0;
            err_ff <= 1'b0;
            done_ff <= 1'b0;
            reg_ff <= 8'h00;
            dat_ff <= 8'h00;
            dev_ff <= 7'h00;
        end else begin
            done_ff <= 1'b0;
            if (st_ff == M_IDLE && REQ_I) begin
                st_ff <= M_START;
                ph_ff <= 2'h0;
                rd_ff <= RD_I;
                dev_ff <= DEV_ADDR_I;
                reg_ff <= REG_I;
                dat_ff <= DATA_I;
                err_ff <= 1'b0;
            end else if (tick) begin
                ph_ff <= ph_ff + 2'h1;
                unique case (st_ff)
                    M_IDLE: begin
                        scl_ff <= 1'b1;
                    end
                    M_START, M_RSTART: begin
                        unique case (ph_ff)
                            2'h0: sda_ff <= 1'b1;
                            2'h1: scl_ff <= 1'b1;
                            2'h2: sda_ff <= 1'b0;
                            default: begin
                                scl_ff <= 1'b0;
                                st_ff <= M_BYTE;
                                bit_ff <= 4'h0;
                                idx_ff <= (st_ff == M_RSTART) ? 2'h2 : 2'h0;
                                tx_ff <= (st_ff == M_RSTART) ? {dev_ff, 1'b1}
                                                              : {dev_ff, 1'b0};
                            end
                        endcase
                    end
                    M_BYTE: begin
                        unique case (ph_ff)
                            2'h0: begin
                                if (bit_ff == ACK_SLOT) begin
                                    // Single-byte reads end with no ack
                                    sda_ff <= 1'b1;
                                end else begin
                                    sda_ff <= rx_byte ? 1'b1 : tx_ff[7];
                                end
                            end
                            2'h1: scl_ff <= 1'b1;
                            2'h2: begin
                                if (bit_ff == ACK_SLOT && !rx_byte && sda_sync_ff[1]) begin
                                    err_ff <= 1'b1;
                                end
                                if (bit_ff != ACK_SLOT) begin
                                    if (rx_byte) begin
                                        rx_ff <= {rx_ff[6:0], sda_sync_ff[1]};
                                    end
                                    tx_ff <= {tx_ff[6:0], 1'b0};
                                end
                            end
                            default: begin
                                scl_ff <= 1'b0;
                                bit_ff <= bit_ff + 4'h1;
                                if (bit_ff == ACK_SLOT) begin
                                    bit_ff <= 4'h0;
                                    idx_ff <= idx_ff + 2'h1;
                                    tx_ff <= (idx_ff == 2'h0) ? reg_ff : dat_ff;
                                    if (err_ff || last) begin
                                        st_ff <= M_STOP;
                                    end else if (rd_ff && idx_ff == 2'h1) begin
                                        st_ff <= M_RSTART;
                                    end
                                end
                            end
                        endcase
                    end
                    M_STOP: begin
                        unique case (ph_ff)
                            2'h0: sda_ff <= 1'b0;
                            2'h1: scl_ff <= 1'b1;
                            2'h2: sda_ff <= 1'b1;
                            default: begin
                                st_ff <= M_IDLE;
                                done_ff <= 1'b1;
                            end
                        endcase
                    end
                    default: st_ff <= M_IDLE;
                endcase
            end
        end
    end

    assign READY_O = (st_ff == M_IDLE);
    assign DONE_O = done_ff;
    assign ACK_ERR_O = err_ff;
    assign RDATA_O = rx_ff;
    assign BUS.scl_o = 1'b0;
    assign BUS.scl_oe = ~scl_ff;
    assign BUS.sda_mst_o = 1'b0;
    assign BUS.sda_mst_oe = ~sda_ff;
endmodule : isp_master

// [sim/isp_props.sv]
`timescale 1ns/1ps
module isp_props
    import isp_pkg::*;
(
    input wire logic CORE_CLK_I,
    input wire logic RST_B_I,
    input wire logic ADDR_SEL_I,
    input wire logic IF_SEL_I,
    input wire logic scl,
    input wire logic sda,
    input wire logic sda_dev_o,
    input wire logic sda_dev_oe
);
    logic scl_q_ff, sda_q_ff, busy_ff, match_ff, rd_ff;
    logic [3:0] cnt_ff;
    logic [7:0] shreg_ff;
    logic [7:0] byte_n_ff;
    logic start_ev, stop_ev, rise_ev;
    logic [6:0] own_addr;
    assign start_ev = scl && scl_q_ff && sda_q_ff && !sda;
    assign stop_ev = scl && scl_q_ff && !sda_q_ff && sda;
    assign rise_ev = scl && !scl_q_ff;
    assign own_addr = ADDR_SEL_I ? ADDR_ALT : ADDR_BASE;

    always_ff @(posedge CORE_CLK_I or negedge RST_B_I) begin
        if (!RST_B_I) begin
            scl_q_ff <= 1'b1;
            sda_q_ff <= 1'b1;
            busy_ff <= 1'b0;
        end else begin
            scl_q_ff <= scl;
            sda_q_ff <= sda;
            busy_ff <= start_ev | (busy_ff & ~stop_ev);
        end
    end

    // Bit and byte position within the frame, restarted by every START
    always_ff @(posedge CORE_CLK_I or negedge RST_B_I) begin
        if (!RST_B_I) begin
            cnt_ff <= 4'h0;
            byte_n_ff <= 8'h00;
            shreg_ff <= 8'h00;
            match_ff <= 1'b0;
            rd_ff <= 1'b0;
        end else if (start_ev) begin
            cnt_ff <= 4'h0;
            byte_n_ff <= 8'h00;
            match_ff <= 1'b0;
        end else if (rise_ev) begin
            shreg_ff <= {shreg_ff[6:0], sda};
            cnt_ff <= (cnt_ff == 4'h8) ? 4'h0 : cnt_ff + 4'h1;
            if (cnt_ff == 4'h8 && byte_n_ff != 8'hFF) begin
                byte_n_ff <= byte_n_ff + 8'h01;
            end
            if (cnt_ff == 4'h8 && byte_n_ff == 8'h00) begin
                match_ff <= !IF_SEL_I && (shreg_ff[7:1] == own_addr);
                rd_ff <= shreg_ff[0];
            end
        end
    end

    default clocking @(posedge CORE_CLK_I); endclocking
    default disable iff (!RST_B_I);

    sequence ninth_rise;
        rise_ev && cnt_ff == 4'h8;
    endsequence

    chk_sda_hold_high: assert property (scl && $past(scl) |-> $stable(sda_dev_oe))
        else $error("device moved SDA while SCL high");
    chk_addr_ack_match: assert property (ninth_rise and (byte_n_ff == 8'h00 && busy_ff)
        |-> sda_dev_oe == (!IF_SEL_I && shreg_ff[7:1] == own_addr))
        else $error("address acknowledge wrong");
    chk_ack_full_pulse: assert property (ninth_rise and sda_dev_oe |-> sda_dev_oe [*8])
        else $error("acknowledge dropped early");
    chk_write_byte_ack: assert property (ninth_rise and (byte_n_ff != 8'h00 && match_ff && !rd_ff)
        |-> sda_dev_oe)
        else $error("received byte not acknowledged");
    chk_read_ack_free: assert property (ninth_rise and (byte_n_ff != 8'h00 && match_ff && rd_ff)
        |-> !sda_dev_oe)
        else $error("device held SDA in master acknowledge");
    chk_foreign_quiet: assert property (busy_ff && !match_ff && byte_n_ff != 8'h00 |-> !sda_dev_oe)
        else $error("device drove SDA when not addressed");
    chk_addr_byte_quiet: assert property (busy_ff && byte_n_ff == 8'h00 && cnt_ff != 4'h8
        |-> !sda_dev_oe)
        else $error("device drove SDA during address byte");
    chk_free_bus_quiet: assert property (!busy_ff |-> !sda_dev_oe && !sda_dev_o)
        else $error("device drove SDA on a free bus");
    chk_free_clock_high: assert property (!busy_ff && !start_ev |-> scl)
        else $error("SCL low on a free bus");
endmodule : isp_props

// [sim/isp_slave_tb.sv]
`timescale 1ns/1ps
`define CHK(act, exp) begin samples_checked++; if ((act) !== (exp)) begin miscompares++; \
    $display("BAD t=%0t got %0h want %0h", $time, act, exp); end end
module isp_slave_tb;
    import isp_pkg::*;
    logic clk = 1'b0;
    logic rst_b = 1'b0;
    logic if_sel = 1'b0;
    logic addr_sel = 1'b0;
    logic req = 1'b0;
    logic rd = 1'b0;
    logic [6:0] dev_addr = 7'h00;
    logic [7:0] reg_sel = 8'h00;
    logic [7:0] wdata = 8'h00;
    logic [7:0] reg_addr, wr_data, rdata, rd_data;
    logic wr_stb, busy, ready, done, ack_err;
    logic [7:0] mem [256];
    logic [7:0] last_addr = 8'h00;
    logic [7:0] last_data = 8'h00;
    logic busy_seen = 1'b0;
    int miscompares = 0;
    int samples_checked = 0;
    int wr_cnt = 0;
    assign rd_data = mem[reg_addr];
    always #25 clk = ~clk;

    isp_bus_if bus();
    isp_slave i_isp_slave (.CORE_CLK_I(clk), .RST_B_I(rst_b), .IF_SEL_I(if_sel),
        .ADDR_SEL_I(addr_sel), .BUS(bus), .REG_ADDR_O(reg_addr), .WR_DATA_O(wr_data),
        .WR_STB_O(wr_stb), .RD_DATA_I(rd_data), .BUSY_O(busy));
    isp_master i_isp_master (.CORE_CLK_I(clk), .RST_B_I(rst_b), .BUS(bus), .REQ_I(req),
        .RD_I(rd), .DEV_ADDR_I(dev_addr), .REG_I(reg_sel), .DATA_I(wdata), .READY_O(ready),
        .DONE_O(done), .ACK_ERR_O(ack_err), .RDATA_O(rdata));
    isp_props i_isp_props (.CORE_CLK_I(clk), .RST_B_I(rst_b), .ADDR_SEL_I(addr_sel),
        .IF_SEL_I(if_sel),
        .scl(bus.scl), .sda(bus.sda), .sda_dev_o(bus.sda_dev_o), .sda_dev_oe(bus.sda_dev_oe));

    initial foreach (mem[i]) mem[i] = REG_RESET;

    // Stands in for the register file behind the port
    always @(posedge clk) begin
        if (wr_stb === 1'b1) begin
            mem[reg_addr] <= wr_data;
            last_addr <= reg_addr;
            last_data <= wr_data;
            wr_cnt++;
        end
        if (busy === 1'b1) busy_seen <= 1'b1;
    end

    task automatic stop_test;
        $display("checked %0d mismatches %0d", samples_checked, miscompares);
        if (miscompares == 0 && samples_checked > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : stop_test

    // One request, held until the edge that takes it, then wait for completion
    task automatic xfer(input logic r, input logic [6:0] a, input logic [7:0] g,
                        input logic [7:0] d);
        int n;
        n = 0;
        @(negedge clk);
        rd = r;
        dev_addr = a;
        reg_sel = g;
        wdata = d;
        busy_seen = 1'b0;
        req = 1'b1;
        @(negedge clk);
        req = 1'b0;
        while (done !== 1'b1 && n < 20000) begin
            @(negedge clk);
            n++;
        end
        if (n >= 20000) begin
            miscompares++;
            $display("BAD t=%0t transfer never completed", $time);
        end
    endtask : xfer

    // Seven frames of at most 15600 cycles, about 64000 in all; ample margin
    initial begin
        #4500000;
        miscompares++;
        stop_test();
    end

    initial begin
        int n0;
        repeat (2) @(posedge clk);
        @(negedge clk);
        rst_b = 1'b1;
        @(negedge clk);
        `CHK(busy, 1'b0)
        `CHK(bus.sda, 1'b1)
        `CHK(ready, 1'b1)
        xfer(1'b0, ADDR_BASE, 8'h05, 8'hA5);
        `CHK(ack_err, 1'b0)
        `CHK(wr_cnt, 1)
        `CHK(last_addr, 8'h05)
        `CHK(last_data, 8'hA5)
        `CHK(reg_addr, 8'h06)
        `CHK(busy_seen, 1'b1)
        `CHK(busy, 1'b0)
        xfer(1'b1, ADDR_BASE, 8'h05, 8'h00);
        `CHK(rdata, 8'hA5)
        `CHK(ack_err, 1'b0)
        `CHK(reg_addr, 8'h06)
        for (int s = 0; s < 2; s++) begin
            for (int a = 0; a < 2; a++) begin
                @(negedge clk);
                addr_sel = s[0];
                repeat (4) @(negedge clk);
                n0 = wr_cnt;
                xfer(1'b0, a[0] ? ADDR_ALT : ADDR_BASE, 8'h20, 8'h3C);
                `CHK(ack_err, logic'(s != a))
                `CHK(wr_cnt - n0, (s == a) ? 1 : 0)
            end
        end
        `CHK(mem[8'h20], 8'h3C)
        @(negedge clk);
        addr_sel = 1'b0;
        if_sel = 1'b1;
        repeat (4) @(negedge clk);
        n0 = wr_cnt;
        xfer(1'b0, ADDR_BASE, 8'h07, 8'h81);
        `CHK(ack_err, 1'b1)
        `CHK(wr_cnt - n0, 0)
        stop_test();
    end
endmodule : isp_slave_tb
